// File: logic/cft_consts.svh
// Register offsets, reset values, write masks and field positions of the CAN FD timing block.
`ifndef CFT_CONSTS_SVH
`define CFT_CONSTS_SVH
`define CFT_OFF_NBH 8'h00
`define CFT_OFF_NBL 8'h04
`define CFT_OFF_DBH 8'h08
`define CFT_OFF_DBL 8'h0C
`define CFT_OFF_TDCH 8'h10
`define CFT_OFF_TDCL 8'h14
`define CFT_OFF_TBCH 8'h18
`define CFT_OFF_TBCL 8'h1C
`define CFT_OFF_TSCTL 8'h20
`define CFT_OFF_TSPRE 8'h24
`define CFT_OFF_MODE 8'h28
`define CFT_RST_NBH 16'h003E
`define CFT_RST_NBL 16'h0F0F
`define CFT_RST_DBH 16'h000E
`define CFT_RST_DBL 16'h0303
`define CFT_RST_TDCH 16'h0002
`define CFT_RST_TDCL 16'h1000
`define CFT_RST_MODE 3'h4
`define CFT_MSK_NBH 16'hFFFF
`define CFT_MSK_NBL 16'h7F7F
`define CFT_MSK_DBH 16'hFF1F
`define CFT_MSK_DBL 16'h0F0F
`define CFT_MSK_TDCH 16'h0303
`define CFT_MSK_TDCL 16'h7F3F
`define CFT_MODE_CFG 3'h4
`define CFT_MODE_DIS 3'h1
`define CFT_BIT_EDGE_FILT 9
`define CFT_BIT_EXT_ID 8
`endif

// File: logic/cft_pkg.sv
// Types shared by the CAN FD timing block.
`default_nettype none
package cft_pkg;
	typedef enum logic [1:0] {
		cft_ph_sync = 2'b00,
		cft_ph_seg1 = 2'b01,
		cft_ph_seg2 = 2'b10
	} cft_phase_t;
	typedef enum logic [1:0] {
		cft_tdc_off = 2'b00,
		cft_tdc_manual = 2'b01,
		cft_tdc_auto = 2'b10,
		cft_tdc_auto_alt = 2'b11
	} cft_tdc_mode_t;
endpackage : cft_pkg
`default_nettype wire

// File: logic/cft_bit_timer.sv
// Bit timer: quantum prescaler, segment sequencing and resynchronisation.
`default_nettype none
module cft_bit_timer #(
	parameter int S1W = 8,
	parameter int S2W = 7,
	parameter int JW = 7
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic edge_i,
	input wire logic [7:0] presc_i,
	input wire logic [S1W-1:0] seg1_i,
	input wire logic [S2W-1:0] seg2_i,
	input wire logic [JW-1:0] sjw_i,
	output logic sample_o,
	output logic bit_end_o
);
	typedef struct packed {
		cft_pkg::cft_phase_t ph;
		logic [7:0] qc;
		logic [9:0] cnt;
		logic [9:0] ext;
		logic done;
		logic smp;
		logic be;
	} cft_bt_state_t;
	localparam cft_bt_state_t BT_RST = '{ph: cft_pkg::cft_ph_sync, default: '0};
	cft_bt_state_t s;
	cft_bt_state_t n;
	logic tick;
	logic [9:0] l1;
	logic [9:0] l2;
	logic [9:0] lj;

	function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
		return (a < b) ? a : b;
	endfunction : min10

	// --------------------------------------------------------------------
	// Segment sequencer
	// --------------------------------------------------------------------
	// One resync per bit; a later edge in the same bit is ignored on purpose.
	always_comb begin
		tick = run_i && (s.qc == presc_i);
		l1 = 10'(seg1_i) + 10'h001;
		l2 = 10'(seg2_i) + 10'h001;
		lj = 10'(sjw_i) + 10'h001;
		n = s;
		n.smp = 1'b0;
		n.be = 1'b0;
		if (!run_i) begin
			n = BT_RST;
		end else begin
			n.qc = tick ? 8'h00 : s.qc + 8'h01;
			if (edge_i && !s.done) begin
				n.done = 1'b1;
				case (s.ph)
					cft_pkg::cft_ph_seg1: n.ext = min10(s.cnt + 10'h001, lj);
					cft_pkg::cft_ph_seg2: n.cnt = s.cnt + min10(l2 - s.cnt - 10'h001, lj);
					default: n.done = 1'b1;
				endcase
			end
			if (tick) begin
				case (n.ph)
					cft_pkg::cft_ph_sync: begin
						n.ph = cft_pkg::cft_ph_seg1;
						n.cnt = 10'h000;
					end
					cft_pkg::cft_ph_seg1: begin
						if (n.cnt >= l1 + n.ext - 10'h001) begin
							n.ph = cft_pkg::cft_ph_seg2;
							n.cnt = 10'h000;
							n.smp = 1'b1;
						end else begin
							n.cnt = n.cnt + 10'h001;
						end
					end
					cft_pkg::cft_ph_seg2: begin
						if (n.cnt >= l2 - 10'h001) begin
							n = BT_RST;
							n.be = 1'b1;
						end else begin
							n.cnt = n.cnt + 10'h001;
						end
					end
					default: n.ph = cft_pkg::cft_ph_sync;
				endcase
			end
		end
	end

	// State register.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= BT_RST;
		end else begin
			s <= n;
		end
	end

	assign sample_o = s.smp;
	assign bit_end_o = s.be;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_quantum_wrap: assert property ((run_i && s.qc == presc_i) |=> s.qc == 8'h00)
		else $error("quantum prescaler did not wrap");
	a_sample_place: assert property (s.smp |-> (s.ph == cft_pkg::cft_ph_seg2 && s.cnt == 10'h000))
		else $error("sample point outside the end of segment one");
	c_bit_end: cover property (s.be);
endmodule : cft_bit_timer
`default_nettype wire

// File: logic/cft_timing.sv
// CAN FD bit timing, delay compensation and time base block with an APB slave.
`default_nettype none
`include "cft_consts.svh"
module cft_timing #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rx_i,
	input wire logic integrating_i,
	input wire logic data_phase_i,
	input wire logic [5:0] meas_delay_i,
	input wire logic [10:0] base_id_i,
	input wire logic rrs_i,
	output logic nom_sample_o,
	output logic nom_bit_end_o,
	output logic data_sample_o,
	output logic data_bit_end_o,
	output logic [15:0] ssp_pos_o,
	output logic ssp_enable_o,
	output logic [11:0] frame_id_o,
	output logic [2:0] operating_mode_status_o,
	output logic [31:0] timestamp_counter_o
);
	typedef struct packed {
		logic [15:0] nbh;
		logic [15:0] nbl;
		logic [15:0] dbh;
		logic [15:0] dbl;
		logic [15:0] tdch;
		logic [15:0] tdcl;
		logic [31:0] timestamp_counter;
		logic ts_en;
		logic [9:0] ts_pre;
		logic [9:0] pre_cnt;
		logic [2:0] mode;
		logic [31:0] rdata;
		logic rdy;
		logic err;
		logic rx_q;
		logic pend;
		logic edge_det;
		logic [15:0] secondary_sample_point;
		logic ssp_en;
		logic [11:0] fid;
	} cft_top_state_t;

	localparam cft_top_state_t ST_RST = '{
		nbh: `CFT_RST_NBH,
		nbl: `CFT_RST_NBL,
		dbh: `CFT_RST_DBH,
		dbl: `CFT_RST_DBL,
		tdch: `CFT_RST_TDCH,
		tdcl: `CFT_RST_TDCL,
		mode: `CFT_RST_MODE,
		rx_q: 1'b1,
		default: '0
	};

	cft_top_state_t s;
	cft_top_state_t n;
	logic setup;
	logic wr_ok;
	logic tbc_wr;
	logic hit;
	logic filt;
	logic fall;
	logic run_nom;
	logic run_dat;
	logic [15:0] rd;
	logic [15:0] seg1_clk;

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	// Registers that only configuration mode may change.
	function automatic logic is_locked(input logic [ADDR_W-1:0] a);
		return (a == `CFT_OFF_NBH) || (a == `CFT_OFF_NBL) || (a == `CFT_OFF_DBH) ||
			(a == `CFT_OFF_DBL) || (a == `CFT_OFF_TDCH) || (a == `CFT_OFF_TDCL);
	endfunction : is_locked

	// Sign extension of the seven-bit offset to the position width.
	function automatic logic [15:0] sext7(input logic [6:0] v);
		return {{9{v[6]}}, v};
	endfunction : sext7

	// --------------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------------
	// Pready is registered, so every transfer has exactly one access cycle.
	always_comb begin
		n = s;
		setup = psel_i && !penable_i;
		wr_ok = psel_i && penable_i && s.rdy && pwrite_i && !s.err;
		tbc_wr = wr_ok && (paddr_i == `CFT_OFF_TBCH || paddr_i == `CFT_OFF_TBCL);
		hit = 1'b1;
		case (paddr_i)
			`CFT_OFF_NBH: rd = s.nbh;
			`CFT_OFF_NBL: rd = s.nbl;
			`CFT_OFF_DBH: rd = s.dbh;
			`CFT_OFF_DBL: rd = s.dbl;
			`CFT_OFF_TDCH: rd = s.tdch;
			`CFT_OFF_TDCL: rd = s.tdcl;
			`CFT_OFF_TBCH: rd = s.timestamp_counter[31:16];
			`CFT_OFF_TBCL: rd = s.timestamp_counter[15:0];
			`CFT_OFF_TSCTL: rd = {15'h0000, s.ts_en};
			`CFT_OFF_TSPRE: rd = {6'h00, s.ts_pre};
			`CFT_OFF_MODE: rd = {13'h0000, s.mode};
			default: begin
				rd = 16'h0000;
				hit = 1'b0;
			end
		endcase

		// Bus handshake: answer decided in the setup cycle.
		n.rdy = setup;
		if (setup) begin
			n.rdata = pwrite_i ? 32'h0000_0000 : {16'h0000, rd};
			n.err = !hit || (pwrite_i && is_locked(paddr_i) && s.mode != `CFT_MODE_CFG);
		end else if (s.rdy) begin
			n.rdata = 32'h0000_0000;
			n.err = 1'b0;
		end

		// Time base: a disabled counter is held at zero to save power.
		if (!s.ts_en) begin
			n.timestamp_counter = 32'h0000_0000;
			n.pre_cnt = 10'h000;
		end else if (s.pre_cnt == s.ts_pre) begin
			n.timestamp_counter = s.timestamp_counter + 32'h0000_0001;
			n.pre_cnt = 10'h000;
		end else begin
			n.pre_cnt = s.pre_cnt + 10'h001;
		end

		// Register writes, masked so unused bits stay zero.
		if (wr_ok) begin
			case (paddr_i)
				`CFT_OFF_NBH: n.nbh = pwdata_i[15:0] & `CFT_MSK_NBH;
				`CFT_OFF_NBL: n.nbl = pwdata_i[15:0] & `CFT_MSK_NBL;
				`CFT_OFF_DBH: n.dbh = pwdata_i[15:0] & `CFT_MSK_DBH;
				`CFT_OFF_DBL: n.dbl = pwdata_i[15:0] & `CFT_MSK_DBL;
				`CFT_OFF_TDCH: n.tdch = pwdata_i[15:0] & `CFT_MSK_TDCH;
				`CFT_OFF_TDCL: n.tdcl = pwdata_i[15:0] & `CFT_MSK_TDCL;
				`CFT_OFF_TBCH: begin
					if (s.ts_en) begin
						n.timestamp_counter[31:16] = pwdata_i[15:0];
						n.pre_cnt = 10'h000;
					end
				end
				`CFT_OFF_TBCL: begin
					if (s.ts_en) begin
						n.timestamp_counter[15:0] = pwdata_i[15:0];
						n.pre_cnt = 10'h000;
					end
				end
				`CFT_OFF_TSCTL: n.ts_en = pwdata_i[0];
				`CFT_OFF_TSPRE: n.ts_pre = pwdata_i[9:0];
				`CFT_OFF_MODE: n.mode = pwdata_i[2:0];
				default: n.err = 1'b0;
			endcase
		end

		// Edge filter: during integration a falling edge only counts once
		// the line stays dominant for a second clock, which costs one clock
		// of latency but rejects single-clock glitches.
		filt = s.tdch[`CFT_BIT_EDGE_FILT] && integrating_i;
		fall = s.rx_q && !rx_i;
		n.rx_q = rx_i;
		if (filt) begin
			n.edge_det = s.pend && !rx_i;
			n.pend = fall;
		end else begin
			n.edge_det = fall;
			n.pend = 1'b0;
		end

		// Secondary sample point in clocks; the product stays below 8193.
		seg1_clk = (16'(s.dbh[4:0]) + 16'h0001) * (16'(s.dbh[15:8]) + 16'h0001);
		case (cft_pkg::cft_tdc_mode_t'(s.tdch[1:0]))
			cft_pkg::cft_tdc_auto, cft_pkg::cft_tdc_auto_alt: begin
				n.secondary_sample_point = 16'(meas_delay_i) + seg1_clk + sext7(s.tdcl[14:8]);
				n.ssp_en = 1'b1;
			end
			cft_pkg::cft_tdc_manual: begin
				n.secondary_sample_point = 16'(s.tdcl[5:0]) + sext7(s.tdcl[14:8]);
				n.ssp_en = 1'b1;
			end
			default: begin
				n.secondary_sample_point = 16'h0000;
				n.ssp_en = 1'b0;
			end
		endcase

		// Identifier: RRS becomes the lowest bit in the twelve-bit option.
		if (s.tdch[`CFT_BIT_EXT_ID]) begin
			n.fid = {base_id_i, rrs_i};
		end else begin
			n.fid = {1'b0, base_id_i};
		end
	end

	// State register.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// --------------------------------------------------------------------
	// Bit timers
	// --------------------------------------------------------------------
	// Timers idle in configuration and disable modes, so settings never
	// change under a running bit.
	assign run_nom = (s.mode != `CFT_MODE_CFG) && (s.mode != `CFT_MODE_DIS);
	assign run_dat = run_nom && data_phase_i;

	cft_bit_timer #(
		.S1W(8),
		.S2W(7),
		.JW(7)
	) u_nominal (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.run_i(run_nom),
		.edge_i(s.edge_det),
		.presc_i(s.nbh[15:8]),
		.seg1_i(s.nbh[7:0]),
		.seg2_i(s.nbl[14:8]),
		.sjw_i(s.nbl[6:0]),
		.sample_o(nom_sample_o),
		.bit_end_o(nom_bit_end_o)
	);

	cft_bit_timer #(
		.S1W(5),
		.S2W(4),
		.JW(4)
	) u_data (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.run_i(run_dat),
		.edge_i(s.edge_det),
		.presc_i(s.dbh[15:8]),
		.seg1_i(s.dbh[4:0]),
		.seg2_i(s.dbl[11:8]),
		.sjw_i(s.dbl[3:0]),
		.sample_o(data_sample_o),
		.bit_end_o(data_bit_end_o)
	);

	// Outputs straight from state.
	assign prdata_o = s.rdata;
	assign pready_o = s.rdy;
	assign pslverr_o = s.err;
	assign ssp_pos_o = s.secondary_sample_point;
	assign ssp_enable_o = s.ssp_en;
	assign frame_id_o = s.fid;
	assign operating_mode_status_o = s.mode;
	assign timestamp_counter_o = s.timestamp_counter;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_cfg_lock: assert property ((psel_i && penable_i && s.rdy && pwrite_i && is_locked(paddr_i)
		&& s.mode != `CFT_MODE_CFG) |=> ($stable(s.nbh) && $stable(s.nbl) && $stable(s.tdcl)))
		else $error("timing setting changed outside configuration mode");
	a_nbh_store: assert property ((wr_ok && paddr_i == `CFT_OFF_NBH) |=> s.nbh == $past(pwdata_i[15:0]))
		else $error("nominal setting not stored");
	a_unused_zero: assert property (((s.nbl & ~`CFT_MSK_NBL) == 16'h0000)
		&& ((s.dbh & ~`CFT_MSK_DBH) == 16'h0000) && ((s.tdch & ~`CFT_MSK_TDCH) == 16'h0000))
		else $error("unused bit set");
	a_tbc_stop: assert property (!s.ts_en |=> s.timestamp_counter == 32'h0000_0000 && s.pre_cnt == 10'h000)
		else $error("disabled counter not cleared");
	a_tbc_step: assert property ((s.ts_en && s.pre_cnt == s.ts_pre && !tbc_wr)
		|=> s.timestamp_counter == $past(s.timestamp_counter) + 32'h0000_0001)
		else $error("counter did not step at prescaler end");
	a_tbc_hold: assert property ((s.ts_en && s.pre_cnt != s.ts_pre && !tbc_wr) |=> $stable(s.timestamp_counter))
		else $error("counter stepped before prescaler end");
	a_pre_clear: assert property ((tbc_wr && s.ts_en) |=> s.pre_cnt == 10'h000)
		else $error("counter write did not clear prescaler count");
	a_ssp_off: assert property ((s.tdch[1:0] == 2'b00) |=> (!s.ssp_en && s.secondary_sample_point == 16'h0000))
		else $error("compensation active while disabled");
	a_ssp_manual: assert property ((s.tdch[1:0] == 2'b01)
		|=> s.secondary_sample_point == 16'($past(s.tdcl[5:0])) + sext7($past(s.tdcl[14:8])))
		else $error("manual secondary sample point wrong");
	a_ext_id: assert property (s.tdch[`CFT_BIT_EXT_ID] |=> s.fid[0] == $past(rrs_i))
		else $error("RRS not used as lowest identifier bit");
	a_glitch_filter: assert property ((s.tdch[`CFT_BIT_EDGE_FILT] && integrating_i && s.rx_q && !rx_i
		##1 rx_i) |=> !s.edge_det)
		else $error("glitch passed the integration edge filter");
	a_cfg_lock_data: assert property ((psel_i && penable_i && s.rdy && pwrite_i && is_locked(paddr_i)
		&& s.mode != `CFT_MODE_CFG) |=> ($stable(s.dbh) && $stable(s.dbl) && $stable(s.tdch)))
		else $error("data or control setting changed outside configuration mode");
	a_ssp_auto: assert property (s.tdch[1] |=> s.secondary_sample_point == 16'($past(meas_delay_i))
		+ (16'($past(s.dbh[4:0])) + 16'h0001) * (16'($past(s.dbh[15:8])) + 16'h0001)
		+ sext7($past(s.tdcl[14:8])))
		else $error("automatic secondary sample point wrong");
	a_base_id: assert property (!s.tdch[`CFT_BIT_EXT_ID] |=> s.fid == {1'b0, $past(base_id_i)})
		else $error("base identifier not passed through");

	c_write_cfg: cover property (wr_ok && paddr_i == `CFT_OFF_NBH);
	c_refused: cover property (s.err && s.rdy);
	c_tbc_wrap: cover property (s.ts_en && s.timestamp_counter == 32'hFFFF_FFFF ##1 s.timestamp_counter == 32'h0000_0000);
endmodule : cft_timing
`default_nettype wire

// File: tb/cft_can_node.sv
// Bus-side node model: receive line, loop delay and received identifier.
`default_nettype none
module cft_can_node #(
	parameter logic [5:0] LOOP_DELAY = 6'h05,
	parameter logic [10:0] RX_BASE_ID = 11'h5A3,
	parameter logic RX_RRS = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic edge_req_i,
	input wire logic glitch_req_i,
	output logic rx_o,
	output logic [5:0] meas_delay_o,
	output logic [10:0] base_id_o,
	output logic rrs_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] dom_left;
	// A requested edge holds the bus dominant for four clocks, long enough to pass the edge filter.
	// A requested glitch holds it dominant for one clock only, which the filter must reject.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dom_left <= 3'h0;
		end else if (edge_req_i) begin
			dom_left <= 3'h4;
		end else if (glitch_req_i) begin
			dom_left <= 3'h1;
		end else if (dom_left != 3'h0) begin
			dom_left <= dom_left - 3'h1;
		end
	end
	// Outside a requested edge or glitch the line idles recessive.
	assign rx_o = (dom_left == 3'h0);
	assign meas_delay_o = LOOP_DELAY;
	assign base_id_o = RX_BASE_ID;
	assign rrs_o = RX_RRS;
endmodule : cft_can_node
`default_nettype wire

// File: tb/cft_timing_tb.sv
// Self-checking testbench of the CAN FD timing block.
`default_nettype none
`include "cft_consts.svh"
module cft_timing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rx, integrating, data_phase, rrs, edge_req, glitch_req;
	logic nom_sample, nom_bit_end, data_sample, data_bit_end, ssp_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, timestamp_counter;
	logic [5:0] meas;
	logic [10:0] base_id;
	logic [15:0] secondary_sample_point;
	logic [11:0] frame_id;
	logic [2:0] mode;
	int failures, n_checks;
	cft_timing dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.rx_i(rx), .integrating_i(integrating), .data_phase_i(data_phase), .meas_delay_i(meas),
		.base_id_i(base_id), .rrs_i(rrs), .nom_sample_o(nom_sample), .nom_bit_end_o(nom_bit_end),
		.data_sample_o(data_sample), .data_bit_end_o(data_bit_end), .ssp_pos_o(secondary_sample_point), .ssp_enable_o(ssp_en),
		.frame_id_o(frame_id), .operating_mode_status_o(mode), .timestamp_counter_o(timestamp_counter));
	cft_can_node node (.core_clk_i(clk), .rst_i(rst), .edge_req_i(edge_req), .glitch_req_i(glitch_req), .rx_o(rx),
		.meas_delay_o(meas), .base_id_o(base_id), .rrs_o(rrs));
	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	task report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] rd,
		output logic err);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			failures++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk($sformatf("write error %h", a), {31'h0, exp_err}, {31'h0, e});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 16'h0000, r, e);
		chk($sformatf("reg %h", a), {16'h0000, exp}, r);
	endtask : rd
	function automatic logic pulse(input int s);
		case (s)
			0: return nom_sample;
			1: return nom_bit_end;
			2: return data_sample;
			default: return data_bit_end;
		endcase
	endfunction : pulse
	// Cycles from one pulse of kind a to the next pulse of kind b, bounded.
	task automatic gap(input int a, input int b, output int n);
		int k;
		k = 0;
		n = 0;
		while (pulse(a) !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		do begin
			@(posedge clk);
			n++;
		end while (pulse(b) !== 1'b1 && n < 200);
		if (k >= 200 || n >= 200) begin
			failures++;
			report_and_stop();
		end
	endtask : gap
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] offs[6] = '{`CFT_OFF_NBH, `CFT_OFF_NBL, `CFT_OFF_DBH, `CFT_OFF_DBL, `CFT_OFF_TDCH, `CFT_OFF_TDCL};
		logic [15:0] vals[6] = '{`CFT_RST_NBH, `CFT_RST_NBL, `CFT_RST_DBH, `CFT_RST_DBL, `CFT_RST_TDCH, `CFT_RST_TDCL};
		logic [15:0] msks[6] = '{`CFT_MSK_NBH, `CFT_MSK_NBL, `CFT_MSK_DBH, `CFT_MSK_DBL, `CFT_MSK_TDCH, `CFT_MSK_TDCL};
		chk("mode", 32'h4, {29'h0, mode});
		rd(`CFT_OFF_TBCH, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rd(offs[i], vals[i]);
			wr(offs[i], 16'hFFFF, 1'b0);
			rd(offs[i], msks[i]);
		end
		wr(8'h30, 16'h1234, 1'b1);
	endtask : t_reset
	// Secondary sample point in manual, auto and off modes, and identifier width.
	task automatic t_ssp();
		wr(`CFT_OFF_DBH, 16'h0001, 1'b0);
		wr(`CFT_OFF_DBL, 16'h0000, 1'b0);
		wr(`CFT_OFF_TDCL, 16'h7F0A, 1'b0);
		wr(`CFT_OFF_TDCH, 16'h0101, 1'b0);
		repeat (3) @(posedge clk);
		chk("ssp manual", 32'h9, {16'h0, secondary_sample_point});
		chk("ssp on", 32'h1, {31'h0, ssp_en});
		chk("id ext", 32'hB47, {20'h0, frame_id});
		wr(`CFT_OFF_TDCL, 16'h400A, 1'b0);
		for (int m = 2; m < 4; m++) begin
			wr(`CFT_OFF_TDCH, 16'(m), 1'b0);
			repeat (3) @(posedge clk);
			chk("ssp auto", 32'hFFC7, {16'h0, secondary_sample_point});
			chk("id base", 32'h5A3, {20'h0, frame_id});
		end
		wr(`CFT_OFF_TDCH, 16'h0200, 1'b0);
		repeat (3) @(posedge clk);
		chk("ssp off", 32'h0, {31'h0, ssp_en});
	endtask : t_ssp
	// Bit lengths in both phases, locked settings and one resynchronising edge.
	task automatic t_bits();
		int n;
		wr(`CFT_OFF_NBH, 16'h0102, 1'b0);
		wr(`CFT_OFF_NBL, 16'h0100, 1'b0);
		wr(`CFT_OFF_MODE, 16'h0000, 1'b0);
		wr(`CFT_OFF_NBH, 16'h00FF, 1'b1);
		rd(`CFT_OFF_NBH, 16'h0102);
		data_phase <= 1'b1;
		gap(1, 1, n);
		chk("nominal bit", 32'd12, n);
		gap(0, 1, n);
		chk("nominal seg2", 32'd4, n);
		gap(3, 3, n);
		chk("data bit", 32'd4, n);
		gap(2, 3, n);
		chk("data seg2", 32'd1, n);
		// A filtered edge one quantum into segment one stretches it by one jump width.
		integrating <= 1'b1;
		gap(0, 1, n);
		edge_req <= 1'b1;
		@(posedge clk);
		edge_req <= 1'b0;
		for (n = 2; n < 40 && nom_sample !== 1'b1; n++) @(posedge clk);
		chk("resync sample", 32'd11, n);
		// A one-clock glitch during integration must not move the sample point.
		gap(0, 1, n);
		glitch_req <= 1'b1;
		@(posedge clk);
		glitch_req <= 1'b0;
		for (n = 2; n < 40 && nom_sample !== 1'b1; n++) @(posedge clk);
		chk("glitch sample", 32'd9, n);
		integrating <= 1'b0;
		data_phase <= 1'b0;
		wr(`CFT_OFF_MODE, 16'h0004, 1'b0);
	endtask : t_bits
	// Time base: step rate, upper half access, wrap, stop and clear.
	task automatic t_tbc();
		int n;
		logic [31:0] v;
		wr(`CFT_OFF_TSPRE, 16'h0003, 1'b0);
		wr(`CFT_OFF_TSCTL, 16'h0001, 1'b0);
		v = timestamp_counter;
		for (n = 0; n < 50 && timestamp_counter === v; n++) @(posedge clk);
		v = timestamp_counter;
		for (n = 0; n < 50 && timestamp_counter === v; n++) @(posedge clk);
		chk("step period", 32'd4, n);
		wr(`CFT_OFF_TBCH, 16'h1234, 1'b0);
		rd(`CFT_OFF_TBCH, 16'h1234);
		wr(`CFT_OFF_TSPRE, 16'h0000, 1'b0);
		wr(`CFT_OFF_TBCH, 16'hFFFF, 1'b0);
		wr(`CFT_OFF_TBCL, 16'hFFFF, 1'b0);
		@(posedge clk);
		chk("wrapped", 32'h0, timestamp_counter);
		wr(`CFT_OFF_TSCTL, 16'h0000, 1'b0);
		@(posedge clk);
		chk("stopped", 32'h0, timestamp_counter);
		wr(`CFT_OFF_TBCH, 16'h5555, 1'b0);
		rd(`CFT_OFF_TBCH, 16'h0000);
	endtask : t_tbc
	// ----------------------------------------
	// Clock, reset and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, integrating, data_phase, edge_req, glitch_req} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_ssp();
		t_bits();
		t_tbc();
		report_and_stop();
	end
endmodule : cft_timing_tb
`default_nettype wire
